/* File: id_tag_core.sv */
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/1ns
// Function
// - Nine stored words, sixteen bits each
// - Sends identification words continuously, unprompted
// - Option word picks coding and rate
// - Partial lock: words 4-8 after password
// - Complete lock refuses every store word write
// - Bit period is carrier over 32/64
// - Bits sent by switching antenna load
// - Modulate only once supply reaches reset level
// - Supply below level releases the load
// - Bit0 rate, bit1 coding select
// - Bit2 full lock, bit3 partial lock
// - Options latched at power-on only
// - Full lock ignores reader modulation
module id_tag_core
    import tag_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter logic [NWORDS*WORD_W-1:0] STORE_INIT = '0,
    parameter int FIFO_DEPTH_P = FIFO_DEPTH
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic nvm_rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic carrier_in,
    input wire logic supply_ok_in,
    input wire logic field_mod_in,
    output logic mod_load
);
    import tag_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic car_s1, car_s2, car_s3, sup_s1, sup_s2, fm_s1, fm_s2;
    logic car_rise;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            car_s1 <= 1'b0;
            car_s2 <= 1'b0;
            car_s3 <= 1'b0;
            sup_s1 <= 1'b0;
            sup_s2 <= 1'b0;
            fm_s1 <= 1'b0;
            fm_s2 <= 1'b0;
        end else begin
            car_s1 <= carrier_in;
            car_s2 <= car_s1;
            car_s3 <= car_s2;
            sup_s1 <= supply_ok_in;
            sup_s2 <= sup_s1;
            fm_s1 <= field_mod_in;
            fm_s2 <= fm_s1;
        end
    end
    assign car_rise = car_s2 && !car_s3;

    // ------------------------------------------------------------
    // Nonvolatile store
    // ------------------------------------------------------------
    logic [WORD_W-1:0] store_r [NWORDS];
    logic [WORD_W-1:0] store_nxt [NWORDS];

    // Own reset: the store survives power-on resets of the core
    genvar gi;
    generate
        for (gi = 0; gi < NWORDS; gi++) begin : g_word
            always_ff @(posedge pclk or negedge nvm_rstn) begin
                if (!nvm_rstn) begin
                    store_r[gi] <= STORE_INIT[gi*WORD_W +: WORD_W];
                end else begin
                    store_r[gi] <= store_nxt[gi];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Power-on latch of the option word and control state
    // ------------------------------------------------------------
    tx_state_t state_r, state_nxt;
    opt_t opt_r, opt_nxt;
    mode_t mode_r, mode_nxt;
    logic txen_r, txen_nxt, seen_r, seen_nxt;
    logic [2:0] pw_cnt_r, pw_cnt_nxt;
    logic pw_ok, run, suspend;
    logic commit;
    logic [ADDR_W-3:0] widx;
    logic word_hit;
    logic [WORD_W-1:0] opt_word;

    assign opt_word = store_r[OPT_WORD];
    assign pw_ok = (pw_cnt_r == 3'(PW_WORDS));
    // Reader modulation pauses sending unless fully locked
    assign suspend = fm_s2 && (mode_r != MODE_READ_ONLY);
    assign run = (state_r == ST_RUN);

    always_comb begin
        state_nxt = state_r;
        opt_nxt = opt_r;
        mode_nxt = mode_r;
        case (state_r)
            ST_LATCH: begin
                opt_nxt.speed = opt_word[OPT_SPEED_BIT];
                opt_nxt.code = opt_word[OPT_CODE_BIT];
                opt_nxt.wp = opt_word[OPT_WP_BIT];
                opt_nxt.rw = opt_word[OPT_RW_BIT];
                if (opt_word[OPT_WP_BIT]) begin
                    mode_nxt = MODE_READ_ONLY;
                end else if (opt_word[OPT_RW_BIT]) begin
                    mode_nxt = MODE_PROT;
                end else begin
                    mode_nxt = MODE_UNPROT;
                end
                state_nxt = ST_HOLD;
            end
            ST_RUN: begin
                if (!sup_s2 || !txen_r || suspend) begin
                    state_nxt = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (sup_s2 && txen_r && !suspend) begin
                    state_nxt = ST_RUN;
                end
            end
            default: state_nxt = ST_LATCH;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_LATCH;
            opt_r <= '0;
            mode_r <= MODE_UNPROT;
        end else begin
            state_r <= state_nxt;
            opt_r <= opt_nxt;
            mode_r <= mode_nxt;
        end
    end

    // ------------------------------------------------------------
    // APB slave, one wait state
    // ------------------------------------------------------------
    logic ack_r, ack_nxt, err_r, err_nxt, wr_ok;
    logic [31:0] rd_r, rd_nxt;
    stat_t stat;

    assign widx = paddr[ADDR_W-1:2];
    assign word_hit = (paddr[1:0] == 2'b00) && (paddr >= OFF_WORD0)
        && (widx < (ADDR_W-2)'(NWORDS));
    assign commit = psel && penable && ack_r;
    // Lock mode decides which words may be rewritten
    assign wr_ok = (mode_r == MODE_UNPROT)
        || (mode_r == MODE_PROT && pw_ok
            && widx >= (ADDR_W-2)'(PROT_FIRST));

    assign stat = '{running: run, load: mod_load, supply: sup_s2,
        reader_seen: seen_r, pw_ok: pw_ok, mode: mode_r, opt: opt_r};

    always_comb begin
        ack_nxt = psel && penable && !ack_r;
        err_nxt = 1'b0;
        rd_nxt = '0;
        if (psel && penable && !ack_r) begin
            if (word_hit) begin
                rd_nxt = {16'h0000, store_r[widx[3:0]]};
                err_nxt = pwrite && !wr_ok;
            end else if (paddr == OFF_STAT) begin
                rd_nxt = 32'(stat);
            end else if (paddr == OFF_CTRL) begin
                rd_nxt = {31'h0, txen_r};
            end else if (paddr == OFF_PASS) begin
                err_nxt = !pwrite;
            end else begin
                err_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ack_r <= 1'b0;
            err_r <= 1'b0;
            rd_r <= '0;
        end else begin
            ack_r <= ack_nxt;
            err_r <= err_nxt;
            rd_r <= rd_nxt;
        end
    end

    assign pready = ack_r;
    assign pslverr = ack_r && err_r;
    assign prdata = rd_r;

    // Register write effects, password exchange, sticky flag
    always_comb begin
        for (int i = 0; i < NWORDS; i++) begin
            store_nxt[i] = store_r[i];
        end
        txen_nxt = txen_r;
        pw_cnt_nxt = pw_cnt_r;
        seen_nxt = seen_r;
        if (commit && pwrite && !err_r) begin
            if (word_hit) begin
                store_nxt[widx[3:0]] = pwdata[WORD_W-1:0];
            end else if (paddr == OFF_CTRL) begin
                txen_nxt = pwdata[CTRL_TXEN_BIT];
            end else if (paddr == OFF_PASS && mode_r == MODE_PROT
                && !pw_ok) begin
                if (pwdata[WORD_W-1:0] == store_r[pw_cnt_r[1:0]]) begin
                    pw_cnt_nxt = pw_cnt_r + 3'd1;
                end else begin
                    pw_cnt_nxt = 3'd0;
                end
            end else if (paddr == OFF_STAT && pwdata[STAT_SEEN_BIT]) begin
                seen_nxt = 1'b0;
            end
        end
        // Set beats a clear in the same cycle
        if (suspend) begin
            seen_nxt = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txen_r <= CTRL_TXEN_RST;
            pw_cnt_r <= 3'd0;
            seen_r <= 1'b0;
        end else begin
            txen_r <= txen_nxt;
            pw_cnt_r <= pw_cnt_nxt;
            seen_r <= seen_nxt;
        end
    end

    // ------------------------------------------------------------
    // Bit clock from the carrier
    // ------------------------------------------------------------
    logic [6:0] div;
    logic [5:0] cc_r, cc_nxt;
    logic bit_tick, half_tick, bt_d_r, ht_d_r;

    assign div = opt_r.speed ? DIV_FAST : DIV_SLOW;
    assign bit_tick = run && car_rise && (cc_r == 6'(div - 7'd1));
    assign half_tick = run && car_rise
        && (cc_r == 6'((div >> 1) - 7'd1));

    always_comb begin
        cc_nxt = cc_r;
        if (!run) begin
            cc_nxt = 6'd0;
        end else if (car_rise) begin
            cc_nxt = bit_tick ? 6'd0 : cc_r + 6'd1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cc_r <= 6'd0;
            bt_d_r <= 1'b0;
            ht_d_r <= 1'b0;
        end else begin
            cc_r <= cc_nxt;
            bt_d_r <= bit_tick;
            ht_d_r <= half_tick;
        end
    end

    // ------------------------------------------------------------
    // Word fetch into the FIFO and serialiser
    // ------------------------------------------------------------
    logic [2:0] fidx_r, fidx_nxt;
    logic f_ready, q_valid, pop;
    logic [WORD_W-1:0] q_data, shift_r, shift_nxt;
    logic [3:0] bcnt_r, bcnt_nxt;
    logic have_r, have_nxt, need;

    // Fetch stops when the FIFO fills; words 0..7 then wrap
    assign need = !have_r || (bcnt_r == 4'd15);
    assign pop = bit_tick && need && q_valid;

    always_comb begin
        fidx_nxt = fidx_r;
        if (state_r != ST_LATCH && f_ready) begin
            fidx_nxt = fidx_r + 3'd1;
        end
        shift_nxt = shift_r;
        bcnt_nxt = bcnt_r;
        have_nxt = have_r;
        if (pop) begin
            shift_nxt = q_data;
            bcnt_nxt = 4'd0;
            have_nxt = 1'b1;
        end else if (bit_tick && need) begin
            have_nxt = 1'b0;
        end else if (bit_tick) begin
            shift_nxt = {shift_r[WORD_W-2:0], 1'b0};
            bcnt_nxt = bcnt_r + 4'd1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fidx_r <= 3'd0;
            shift_r <= '0;
            bcnt_r <= 4'd0;
            have_r <= 1'b0;
        end else begin
            fidx_r <= fidx_nxt;
            shift_r <= shift_nxt;
            bcnt_r <= bcnt_nxt;
            have_r <= have_nxt;
        end
    end

    word_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH_P)) u_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .in_valid(state_r != ST_LATCH),
        .in_ready(f_ready),
        .in_data(store_r[fidx_r]),
        .out_valid(q_valid),
        .out_ready(bit_tick && need),
        .out_data(q_data)
    );

    // ------------------------------------------------------------
    // Line coding and load switch
    // ------------------------------------------------------------
    logic enc_level, load_r, load_nxt;

    // No mid-bit strobe before the first word is loaded: a stray
    // one flips the biphase level and glitches the load at start
    line_encoder u_enc (
        .pclk(pclk),
        .presetn(presetn),
        .bit_start(bt_d_r),
        .mid_bit(ht_d_r && have_r),
        .data_bit(shift_r[WORD_W-1]),
        .manchester(opt_r.code),
        .level(enc_level)
    );

    // Load only while running with supply above the reset level
    assign load_nxt = enc_level && have_r && run && sup_s2;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            load_r <= 1'b0;
        end else begin
            load_r <= load_nxt;
        end
    end
    assign mod_load = load_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_supply_release;
        @(posedge pclk) disable iff (!presetn)
        !sup_s2 |=> !load_r;
    endproperty
    a_supply_release: assert property (p_supply_release)
        else $error("load held with supply low");

    property p_no_early_load;
        @(posedge pclk) disable iff (!presetn)
        state_r == ST_LATCH |=> !load_r [*2];
    endproperty
    a_no_early_load: assert property (p_no_early_load)
        else $error("load switched before start");

    property p_read_only_refuse;
        @(posedge pclk) disable iff (!presetn)
        commit && pwrite && word_hit && mode_r == MODE_READ_ONLY
            |-> pslverr;
    endproperty
    a_read_only_refuse: assert property (p_read_only_refuse)
        else $error("write accepted in read-only mode");

    property p_prot_low;
        @(posedge pclk) disable iff (!presetn)
        commit && pwrite && word_hit && mode_r == MODE_PROT
            && (widx < (ADDR_W-2)'(PROT_FIRST) || !pw_ok) |-> pslverr;
    endproperty
    a_prot_low: assert property (p_prot_low)
        else $error("protected word write accepted");

    // Own count of carrier rises, so the check does not lean on cc_r
    logic [6:0] rise_r, rise_nxt;

    always_comb begin
        rise_nxt = rise_r;
        if (!run || bit_tick) begin
            rise_nxt = 7'd0;
        end else if (car_rise) begin
            rise_nxt = rise_r + 7'd1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rise_r <= 7'd0;
        end else begin
            rise_r <= rise_nxt;
        end
    end

    property p_bit_period;
        @(posedge pclk) disable iff (!presetn)
        bit_tick |-> rise_r == (opt_r.speed ? 7'd31 : 7'd63);
    endproperty
    a_bit_period: assert property (p_bit_period)
        else $error("bit period not carrier/32 or /64");

    property p_opt_frozen;
        @(posedge pclk) disable iff (!presetn)
        state_r != ST_LATCH |=> $stable(opt_r) && $stable(mode_r);
    endproperty
    a_opt_frozen: assert property (p_opt_frozen)
        else $error("options changed after power-on latch");

    property p_read_only_ignore;
        @(posedge pclk) disable iff (!presetn)
        run && mode_r == MODE_READ_ONLY && sup_s2 && txen_r |=> run;
    endproperty
    a_read_only_ignore: assert property (p_read_only_ignore)
        else $error("read-only tag reacted to reader");

    property p_msb_first;
        @(posedge pclk) disable iff (!presetn)
        pop |=> shift_r == $past(q_data) && bcnt_r == 4'd0;
    endproperty
    a_msb_first: assert property (p_msb_first)
        else $error("word not loaded for MSB-first send");

    property p_fetch_wrap;
        @(posedge pclk) disable iff (!presetn)
        fidx_r == 3'd7 && f_ready && state_r != ST_LATCH
            |=> fidx_r == 3'd0;
    endproperty
    a_fetch_wrap: assert property (p_fetch_wrap)
        else $error("identification words did not wrap");
endmodule

/* File: tag_pkg.sv */
package tag_pkg;
    // ------------------------------------------------------------
    // Store layout
    // ------------------------------------------------------------
    localparam int NWORDS = 9;
    localparam int ID_WORDS = 8;
    localparam int WORD_W = 16;
    localparam int OPT_WORD = 8;
    localparam int PROT_FIRST = 4;
    localparam int PW_WORDS = 4;
    // Option word fields
    localparam int OPT_SPEED_BIT = 0;
    localparam int OPT_CODE_BIT = 1;
    localparam int OPT_WP_BIT = 2;
    localparam int OPT_RW_BIT = 3;
    // ------------------------------------------------------------
    // Bit clock
    // ------------------------------------------------------------
    localparam logic [6:0] DIV_FAST = 7'd32;
    localparam logic [6:0] DIV_SLOW = 7'd64;
    localparam int FIFO_DEPTH = 32;
    // ------------------------------------------------------------
    // Register map, byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_WORD0 = 8'h00;
    localparam logic [7:0] OFF_PASS = 8'h24;
    localparam logic [7:0] OFF_STAT = 8'h28;
    localparam logic [7:0] OFF_CTRL = 8'h2C;
    localparam int CTRL_TXEN_BIT = 0;
    localparam logic CTRL_TXEN_RST = 1'b1;
    localparam int STAT_SEEN_BIT = 7;

    typedef enum logic [1:0] {
        MODE_UNPROT = 2'b00,
        MODE_PROT = 2'b01,
        MODE_READ_ONLY = 2'b10
    } mode_t;

    typedef enum logic [1:0] {
        ST_LATCH = 2'b00,
        ST_RUN = 2'b01,
        ST_HOLD = 2'b10
    } tx_state_t;

    typedef struct packed {
        logic rw;
        logic wp;
        logic code;
        logic speed;
    } opt_t;

    typedef struct packed {
        logic running;
        logic load;
        logic supply;
        logic reader_seen;
        logic pw_ok;
        mode_t mode;
        opt_t opt;
    } stat_t;
endpackage

/* File: word_fifo.sv */
`timescale 1ns/1ns
module word_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST = (AW)'(DEPTH - 1);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
    logic [AW:0] cnt_r, cnt_nxt;
    logic push, pop;

    assign in_ready = (cnt_r != FULL_CNT);
    assign out_valid = (cnt_r != '0);
    assign out_data = mem_r[rd_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        wr_nxt = wr_r;
        rd_nxt = rd_r;
        cnt_nxt = cnt_r;
        if (push) begin
            wr_nxt = (wr_r == LAST) ? '0 : wr_r + 1'b1;
        end
        if (pop) begin
            rd_nxt = (rd_r == LAST) ? '0 : rd_r + 1'b1;
        end
        if (push && !pop) begin
            cnt_nxt = cnt_r + 1'b1;
        end else if (pop && !push) begin
            cnt_nxt = cnt_r - 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_r <= '0;
            rd_r <= '0;
            cnt_r <= '0;
        end else begin
            wr_r <= wr_nxt;
            rd_r <= rd_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // Storage needs no reset; count guards every read
    always_ff @(posedge pclk) begin
        if (push) begin
            mem_r[wr_r] <= in_data;
        end
    end
endmodule

/* File: line_encoder.sv */
`timescale 1ns/1ns
module line_encoder (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic bit_start,
    input wire logic mid_bit,
    input wire logic data_bit,
    input wire logic manchester,
    output logic level
);
    logic level_r, level_nxt;

    always_comb begin
        level_nxt = level_r;
        if (manchester) begin
            if (bit_start) begin
                level_nxt = data_bit;
            end else if (mid_bit) begin
                level_nxt = !data_bit;
            end
        end else begin
            if (bit_start) begin
                level_nxt = !level_r;
            end else if (mid_bit && !data_bit) begin
                level_nxt = !level_r;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_r <= 1'b0;
        end else begin
            level_r <= level_nxt;
        end
    end

    assign level = level_r;

    property p_manch_mid;
        @(posedge pclk) disable iff (!presetn)
        manchester && mid_bit && !bit_start |=> level_r == !$past(data_bit);
    endproperty
    a_manch_mid: assert property (p_manch_mid)
        else $error("manchester mid-bit level wrong");

    property p_biphase_edge;
        @(posedge pclk) disable iff (!presetn)
        !manchester && bit_start |=> level_r != $past(level_r);
    endproperty
    a_biphase_edge: assert property (p_biphase_edge)
        else $error("biphase boundary transition missing");
endmodule

/* File: reader_model.sv */
`timescale 1ns/1ns
// ------------------------------------------------------------
// Reader: free-running field, amplitude keying on command
// ------------------------------------------------------------
module reader_model (
    output logic carrier,
    output logic field_mod,
    input wire logic modulate
);
    // Field runs free, phase unrelated to the core clock
    initial begin
        carrier = 1'b0;
        #137;
        forever #200 carrier = ~carrier;
    end
    assign field_mod = modulate;
endmodule

/* File: id_tag_core_bench.sv */
`timescale 1ns/1ns
module id_tag_core_bench;
    import tag_pkg::*;
    logic pclk, presetn, nvm_rstn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic carrier_in, supply_ok_in, field_mod_in, mod_load, modulate, er;
    int err_count, comparisons, seed;
    int store [9];

    id_tag_core u_dut (
        .pclk(pclk),
        .presetn(presetn),
        .nvm_rstn(nvm_rstn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .carrier_in(carrier_in),
        .supply_ok_in(supply_ok_in),
        .field_mod_in(field_mod_in),
        .mod_load(mod_load)
    );

    reader_model u_reader (
        .carrier(carrier_in),
        .field_mod(field_mod_in),
        .modulate(modulate)
    );

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task close_out;
        $display("errors %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task chk(input logic [31:0] s, input logic [31:0] x);
        comparisons++;
        if (s !== x) begin
            err_count++;
            $display("wrong value at %0t: got %h want %h", $time, s, x);
        end
    endtask

    // Request stands until the edge at which pready is seen high;
    // read data and error are taken at that same edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
             output logic [31:0] r, output logic e);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            err_count++;
            close_out();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [7:0] a, input int d, input logic e);
        apb(1'b1, a, d, rd, er);
        chk(er, e);
        if (!e && a < OFF_PASS) begin
            store[a/4] = d & 32'hFFFF;
        end
    endtask

    task rdc(input logic [7:0] a, input logic [31:0] m, input int x);
        apb(1'b0, a, 32'h0, rd, er);
        chk(rd & m, x);
    endtask

    task por;
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
    endtask

    // Half-bit samples against the coded stream of the model;
    // the first rise of the load marks the first bit start
    task decode(input int nb, input logic man, input int half);
        int lvl, b, k, n;
        n = 0;
        lvl = 0;
        do begin
            @(negedge pclk);
            n++;
        end while (mod_load !== 1'b1 && n < 4000);
        if (n >= 4000) begin
            err_count++;
            close_out();
        end
        repeat (half/2) @(negedge pclk);
        for (k = 0; k < nb; k++) begin
            b = (store[(k/16)%8] >> (15 - k%16)) & 1;
            lvl = man ? b : 1 - lvl;
            chk(mod_load, lvl);
            repeat (half) @(negedge pclk);
            if (man || b == 0) begin
                lvl = 1 - lvl;
            end
            chk(mod_load, lvl);
            repeat (half) @(negedge pclk);
        end
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        seed = 32'h73e8e4d1;
        err_count = 0;
        comparisons = 0;
        presetn = 1'b0;
        nvm_rstn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        supply_ok_in = 1'b0;
        modulate = 1'b0;
        for (int i = 0; i < 9; i++) begin
            store[i] = 0;
        end
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        nvm_rstn <= 1'b1;
        repeat (600) begin
            @(negedge pclk);
            chk(mod_load, 1'b0);
        end
        @(posedge pclk);
        supply_ok_in <= 1'b1;
        // Word 0 starts with a one so Manchester opens on a rise
        for (int i = 0; i < 8; i++) begin
            wr(4*i, ($random(seed) & 32'hFFFF) | (i == 0 ? 32'h8000 : 0),
               1'b0);
        end
        wr(OFF_WORD0 + 8'h20, 3, 1'b0);
        rdc(OFF_STAT, 32'h3F, 0);
        for (int i = 0; i < 9; i++) begin
            rdc(4*i, 32'hFFFFFFFF, store[i]);
        end
        apb(1'b0, 8'h30, 32'h0, rd, er);
        chk(er, 1'b1);
        por();
        rdc(OFF_STAT, 32'h3F, 32'h03);
        decode(130, 1'b1, 128);
        wr(8'h20, 0, 1'b0);
        por();
        decode(20, 1'b0, 256);
        @(posedge pclk);
        modulate <= 1'b1;
        repeat (8) @(negedge pclk);
        repeat (100) begin
            @(negedge pclk);
            chk(mod_load, 1'b0);
        end
        rdc(OFF_STAT, 32'h480, 32'h80);
        wr(OFF_STAT, 32'h80, 1'b0);
        rdc(OFF_STAT, 32'h80, 32'h80);
        modulate <= 1'b0;
        wr(OFF_STAT, 32'h80, 1'b0);
        rdc(OFF_STAT, 32'h480, 32'h400);
        wr(OFF_CTRL, 0, 1'b0);
        rdc(OFF_STAT, 32'h400, 32'h0);
        rdc(OFF_CTRL, 32'hFFFFFFFF, 32'h0);
        wr(OFF_CTRL, 1, 1'b0);
        apb(1'b0, OFF_PASS, 32'h0, rd, er);
        chk(er, 1'b1);
        wr(8'h20, 8, 1'b0);
        por();
        rdc(OFF_STAT, 32'h3F, 32'h18);
        wr(8'h14, 5, 1'b1);
        for (int i = 0; i < 4; i++) begin
            wr(OFF_PASS, store[i], 1'b0);
        end
        wr(8'h14, 32'h1234, 1'b0);
        wr(8'h00, 0, 1'b1);
        wr(8'h20, 4, 1'b0);
        por();
        modulate <= 1'b1;
        decode(16, 1'b0, 256);
        rdc(OFF_STAT, 32'h3F, 32'h24);
        wr(8'h14, 0, 1'b1);
        wr(8'h20, 0, 1'b1);
        @(posedge pclk);
        supply_ok_in <= 1'b0;
        repeat (20) @(negedge pclk);
        repeat (300) begin
            @(negedge pclk);
            chk(mod_load, 1'b0);
        end
        close_out();
    end
endmodule
